//--- logic/pcmf_clip.sv
// excluded code clipping and 8 bit word forming
`timescale 1ns/1ps
`default_nettype none
`include "pcmf_params.svh"

module pcmf_clip (
  input  wire logic [9:0] raw,
  input  wire logic       mode_8bit,
  output logic      [9:0] word
);

  // ----------------------------------------------------------------
  // clipping
  // ----------------------------------------------------------------
  logic [8:0] rounded; // 8 bit value after rounding, one bit spare

  // round to 8 bits, keep codes inside the permitted range
  always_comb begin
    rounded = {1'b0, raw[9:2]} + {8'h00, raw[1]};
    if (mode_8bit) begin
      // rounding instead of truncation keeps burst accuracy
      if (rounded > `PCMF_CODE8_MAX) begin
        rounded = `PCMF_CODE8_MAX;
      end else if (rounded < `PCMF_CODE8_MIN) begin
        rounded = `PCMF_CODE8_MIN;
      end
      // low two bits driven to zero
      word = {rounded[7:0], `PCMF_FRAC_ZERO};
    end else if (raw > `PCMF_CODE_MAX10) begin
      word = `PCMF_CODE_MAX10;
    end else if (raw < `PCMF_CODE_MIN) begin
      word = `PCMF_CODE_MIN;
    end else begin
      word = raw;
    end
  end

endmodule

`default_nettype wire

//--- logic/pcmf_params.svh
// constants for the composite pal sample formatter
`ifndef PCMF_PARAMS_SVH
`define PCMF_PARAMS_SVH

// ----------------------------------------------------------------
// clock and sample rate
// ----------------------------------------------------------------
// system clock rate in hz
`define PCMF_CLK_HZ          27'd40000000
// quad subcarrier sample rate in hz, 17.734475 mhz
`define PCMF_FSC4_HZ         27'd17734475

// ----------------------------------------------------------------
// sample numbering within a line
// ----------------------------------------------------------------
// samples on a normal line
`define PCMF_LINE_SAMPLES    11'd1135
// samples in the digital active line
`define PCMF_ACTIVE_SAMPLES  11'd948
// samples in the digital horizontal blanking
`define PCMF_BLANK_SAMPLES   11'd187
// first active sample number
`define PCMF_FIRST_ACTIVE    11'd0
// last active sample number
`define PCMF_LAST_ACTIVE     11'd947
// first blanking sample number, a line starts here
`define PCMF_LINE_START      11'd948
// last sample on a normal line
`define PCMF_LAST_NORMAL     11'd1134
// first extra sample on the long lines
`define PCMF_FIRST_EXTRA     11'd1135
// last extra sample on the long lines
`define PCMF_LAST_EXTRA      11'd1136
// samples from the sample after the sync edge to active sample zero
`define PCMF_SYNC_OFFSET     11'd177
// sample number that follows the sync leading edge
`define PCMF_SYNC_SAMPLE     (`PCMF_LINE_SAMPLES - `PCMF_SYNC_OFFSET)
// sync tip length in samples
`define PCMF_SYNC_WIDTH      11'd83

// ----------------------------------------------------------------
// lines and fields
// ----------------------------------------------------------------
// first line of the frame
`define PCMF_FIRST_LINE      10'd1
// lines in a frame
`define PCMF_LINES           10'd625
// long line closing the odd field group
`define PCMF_EXTRA_LINE_A    10'd313
// first line of the even field group
`define PCMF_EVEN_FIRST      10'd314
// first field of the sequence
`define PCMF_FIRST_FIELD     4'd1
// fields in the sequence
`define PCMF_FIELDS          4'd8

// ----------------------------------------------------------------
// sample codes, 10 bit, two fractional bits
// ----------------------------------------------------------------
// blanking level 40.0h
`define PCMF_CODE_BLANK      10'h100
// peak white d3.0h
`define PCMF_CODE_WHITE      10'h34c
// sync tip 01.0h
`define PCMF_CODE_SYNC       10'h004
// lowest permitted code 01.0h
`define PCMF_CODE_MIN        10'h004
// highest permitted 10 bit code fe.ch
`define PCMF_CODE_MAX10      10'h3fb
// lowest permitted 8 bit code 01h
`define PCMF_CODE8_MIN       9'h001
// highest permitted 8 bit code feh
`define PCMF_CODE8_MAX       9'h0fe
// zero fractional bits
`define PCMF_FRAC_ZERO       2'h0

`endif

//--- logic/pcmf_pkg.sv
// types for the composite pal sample formatter
package pcmf_pkg;

  // sampling phase of a word relative to the +u axis
  typedef enum logic [1:0] {
    pcmf_ph_045,
    pcmf_ph_135,
    pcmf_ph_225,
    pcmf_ph_315
  } pcmf_phase_e;

  // level forced onto the stream instead of video
  typedef enum logic [1:0] {
    pcmf_lvl_video,
    pcmf_lvl_blank,
    pcmf_lvl_white,
    pcmf_lvl_sync
  } pcmf_level_e;

  // run control of the formatter
  typedef enum logic {
    pcmf_st_idle,
    pcmf_st_run
  } pcmf_run_e;

  // sample number, line number and field number widths
  typedef logic [10:0] pcmf_sample_t;
  typedef logic [9:0]  pcmf_line_t;
  typedef logic [3:0]  pcmf_field_t;
  typedef logic [9:0]  pcmf_word_t;

endpackage

//--- logic/pcmf_tim_if.sv
// timing carrier between the sample counters and the formatter top
`timescale 1ns/1ps
`default_nettype none

interface pcmf_tim_if;
  logic                  tick;       // new sample position valid
  pcmf_pkg::pcmf_sample_t sample_no; // sample number in line
  pcmf_pkg::pcmf_line_t   line_no;   // line 1 to 625
  pcmf_pkg::pcmf_field_t  field_no;  // field 1 to 8
  pcmf_pkg::pcmf_phase_e  phase;     // subcarrier sampling phase
  logic                  active;     // inside digital active line
  logic                  extra;      // one of the two extra samples
  logic                  sync_ref;   // sample after sync leading edge

  // counters drive, the top reads
  modport timing (
    output tick, sample_no, line_no, field_no, phase, active, extra,
           sync_ref
  );
  modport user (
    input tick, sample_no, line_no, field_no, phase, active, extra,
          sync_ref
  );
endinterface

`default_nettype wire

//--- logic/pcmf_timing.sv
// sample, line, field and phase counters of the pal sample stream
`timescale 1ns/1ps
`default_nettype none
`include "pcmf_params.svh"

module pcmf_timing (
  input  wire logic    clk_sys,
  input  wire logic    resetn,
  input  wire logic    restart,
  input  wire logic    sample_en,
  pcmf_tim_if.timing   tim
);

  // ----------------------------------------------------------------
  // counter state
  // ----------------------------------------------------------------
  pcmf_pkg::pcmf_sample_t sample_no, next_sample_no;
  pcmf_pkg::pcmf_line_t   line_no,   next_line_no;
  pcmf_pkg::pcmf_field_t  field_no,  next_field_no;
  logic [1:0]             phase,     next_phase;
  logic                   tick,      next_tick;

  // long lines carry two extra samples before active sample zero
  function automatic logic is_long(input pcmf_pkg::pcmf_line_t ln);
    return (ln == `PCMF_EXTRA_LINE_A) || (ln == `PCMF_LINES);
  endfunction

  // next counter values, one step per sample enable
  always_comb begin
    next_sample_no = sample_no;
    next_line_no   = line_no;
    next_field_no  = field_no;
    next_phase     = phase;
    next_tick      = sample_en;
    if (restart) begin
      // frame starts at blanking of line 1, field 1
      next_sample_no = `PCMF_LINE_START;
      next_line_no   = `PCMF_FIRST_LINE;
      next_field_no  = `PCMF_FIRST_FIELD;
      next_phase     = 2'h0;
      next_tick      = 1'b0;
    end else if (sample_en) begin
      // four sample phase runs on across lines
      next_phase = phase + 2'h1;
      if (sample_no == `PCMF_LAST_NORMAL) begin
        // extra samples only on the long lines
        next_sample_no = is_long(line_no) ? `PCMF_FIRST_EXTRA
                                          : `PCMF_FIRST_ACTIVE;
      end else if (sample_no == `PCMF_LAST_EXTRA) begin
        next_sample_no = `PCMF_FIRST_ACTIVE;
      end else if (sample_no == `PCMF_LAST_ACTIVE) begin
        // line boundary sits at the start of blanking
        next_sample_no = `PCMF_LINE_START;
        next_line_no   = (line_no == `PCMF_LINES) ? `PCMF_FIRST_LINE
                                                  : line_no + 10'd1;
        // field changes at line 1 and line 314
        if ((line_no == `PCMF_LINES) ||
            (line_no == `PCMF_EXTRA_LINE_A)) begin
          next_field_no = (field_no == `PCMF_FIELDS) ? `PCMF_FIRST_FIELD
                                                     : field_no + 4'd1;
        end
      end else begin
        next_sample_no = sample_no + 11'd1;
      end
    end
  end

  // register the counters
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sample_no <= `PCMF_LINE_START;
      line_no   <= `PCMF_FIRST_LINE;
      field_no  <= `PCMF_FIRST_FIELD;
      phase     <= 2'h0;
      tick      <= 1'b0;
    end else begin
      sample_no <= next_sample_no;
      line_no   <= next_line_no;
      field_no  <= next_field_no;
      phase     <= next_phase;
      tick      <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // carrier outputs
  // ----------------------------------------------------------------
  assign tim.tick      = tick;
  assign tim.sample_no = sample_no;
  assign tim.line_no   = line_no;
  assign tim.field_no  = field_no;
  assign tim.phase     = pcmf_pkg::pcmf_phase_e'(phase);
  assign tim.active    = (sample_no <= `PCMF_LAST_ACTIVE);
  assign tim.extra     = (sample_no >= `PCMF_FIRST_EXTRA);
  assign tim.sync_ref  = (sample_no == `PCMF_SYNC_SAMPLE);

endmodule

`default_nettype wire

//--- logic/pcmf_top.sv
// composite pal 625 line sample stream formatter, top level
`timescale 1ns/1ps
`default_nettype none
`include "pcmf_params.svh"

// Contract
// - words are ten bits, low two optional
// - 8 bit samples sit high, low bits zero
// - one word per quad subcarrier sample clock
// - sampling phases 45 135 225 315 degrees fixed
// - blank 40h, white d3h, sync 01h levels
// - 8 bit codes only 01h through feh
// - 10 bit codes only 01.0h through fe.ch
// - 948 active plus 187 blanking samples
// - numbering 948 to 1134 then 0 to 947
// - odd fields: zero is 177 after sync
// - even fields: zero is 177 after sync
// - lines 313, 625 add samples 1135, 1136
// - grid advances four samples per frame
// - line one sync edge midway between samples
// - digital active window wider than analogue video
module pcmf_top (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic        mode_8bit,
  input  wire logic        auto_blank,
  input  wire logic [1:0]  level_select,
  input  wire logic [9:0]  video_in,
  output logic             video_take,
  output logic             sample_valid,
  output logic      [9:0]  sample_word,
  output logic      [10:0] sample_number,
  output logic      [9:0]  line_number,
  output logic      [3:0]  field_number,
  output logic      [1:0]  quad_phase,
  output logic             active_line,
  output logic             extra_sample,
  output logic             sync_reference,
  output logic             running
);

  // ----------------------------------------------------------------
  // sample rate divider
  // ----------------------------------------------------------------
  // the sample rate is not an integer fraction of the system clock,
  // so a phase accumulator spreads the enables; the enable jitters
  // by one system cycle, which the receiver sees as clock jitter
  logic [26:0] rate_acc;      // phase accumulator
  logic [26:0] next_rate_acc; // next accumulator value
  logic [26:0] rate_sum;      // accumulator plus increment
  logic        sample_en;     // one cycle enable at sample rate
  logic        next_sample_en;// next enable value
  pcmf_pkg::pcmf_run_e state;      // idle or running
  pcmf_pkg::pcmf_run_e next_state; // next run state

  // add the sample rate each cycle, wrap at the clock rate
  always_comb begin
    rate_sum       = rate_acc + `PCMF_FSC4_HZ;
    next_rate_acc  = rate_acc;
    next_sample_en = 1'b0;
    if (state == pcmf_pkg::pcmf_st_run) begin
      if (rate_sum >= `PCMF_CLK_HZ) begin
        // one sample word is due
        next_rate_acc  = rate_sum - `PCMF_CLK_HZ;
        next_sample_en = 1'b1;
      end else begin
        next_rate_acc  = rate_sum;
      end
    end else begin
      // idle keeps the accumulator at its start point
      next_rate_acc = 27'h0000000;
    end
  end

  // register the divider
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rate_acc  <= 27'h0000000;
      sample_en <= 1'b0;
    end else begin
      rate_acc  <= next_rate_acc;
      sample_en <= next_sample_en;
    end
  end

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  logic                restart;    // frame restart to counters

  // start a fresh frame on each idle to run change
  always_comb begin
    next_state = state;
    restart    = 1'b0;
    unique case (state)
      pcmf_pkg::pcmf_st_idle: begin
        if (run) begin
          // counters begin at line 1 field 1
          next_state = pcmf_pkg::pcmf_st_run;
          restart    = 1'b1;
        end
      end
      pcmf_pkg::pcmf_st_run: begin
        if (!run) begin
          next_state = pcmf_pkg::pcmf_st_idle;
        end
      end
    endcase
  end

  // register the run state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= pcmf_pkg::pcmf_st_idle;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // sample counters
  // ----------------------------------------------------------------
  pcmf_tim_if tim (); // counter carrier

  // sample, line and field numbering
  pcmf_timing u_timing (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .restart   (restart),
    .sample_en (sample_en),
    .tim       (tim)
  );

  // ----------------------------------------------------------------
  // sync tip window
  // ----------------------------------------------------------------
  // the sync edge falls between the sample before the reference and
  // the reference itself, so the tip begins on the reference sample
  logic [10:0] sync_left;      // sync tip samples still to send
  logic [10:0] next_sync_left; // next sync tip count
  logic        in_sync;        // current sample lies on sync tip

  // load the tip length less one on the reference sample, count down
  always_comb begin
    next_sync_left = sync_left;
    if (restart) begin
      next_sync_left = 11'd0;
    end else if (tim.tick) begin
      if (tim.sync_ref) begin
        next_sync_left = `PCMF_SYNC_WIDTH - 11'd1;
      end else if (sync_left != 11'd0) begin
        next_sync_left = sync_left - 11'd1;
      end
    end
  end
  assign in_sync = tim.sync_ref || (sync_left != 11'd0);

  // register the sync count
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_left <= 11'd0;
    end else begin
      sync_left <= next_sync_left;
    end
  end

  // ----------------------------------------------------------------
  // level selection
  // ----------------------------------------------------------------
  pcmf_pkg::pcmf_level_e level;   // level chosen for this sample
  logic [9:0]            raw;     // value before clipping
  logic [9:0]            clipped; // value after clipping

  // auto blanking overrides forced levels outside the active line
  always_comb begin
    level = pcmf_pkg::pcmf_level_e'(level_select);
    if (auto_blank && !tim.active) begin
      // outside the digital active line rebuild blanking and sync,
      // the active window already holds the analogue blanking edges
      level = in_sync ? pcmf_pkg::pcmf_lvl_sync
                      : pcmf_pkg::pcmf_lvl_blank;
    end
    unique case (level)
      pcmf_pkg::pcmf_lvl_video: raw = video_in;
      pcmf_pkg::pcmf_lvl_blank: raw = `PCMF_CODE_BLANK;
      pcmf_pkg::pcmf_lvl_white: raw = `PCMF_CODE_WHITE;
      pcmf_pkg::pcmf_lvl_sync:  raw = `PCMF_CODE_SYNC;
    endcase
  end

  // keep every word out of the excluded ranges
  pcmf_clip u_clip (
    .raw       (raw),
    .mode_8bit (mode_8bit),
    .word      (clipped)
  );

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic        next_video_take;   // next take strobe
  logic        next_valid;        // next word strobe
  logic [9:0]  next_word;         // next output word
  logic [10:0] next_number;       // next sample number
  logic [9:0]  next_line;         // next line number
  logic [3:0]  next_field;        // next field number
  logic [1:0]  next_phase;        // next sampling phase
  logic        next_active;       // next active flag
  logic        next_extra;        // next extra sample flag
  logic        next_sync_ref;     // next sync reference flag
  logic        next_running;      // next running flag

  // capture one word and its position per sample tick
  always_comb begin
    next_video_take = sample_en;
    next_valid      = tim.tick && (state == pcmf_pkg::pcmf_st_run);
    next_word       = sample_word;
    next_number     = sample_number;
    next_line       = line_number;
    next_field      = field_number;
    next_phase      = quad_phase;
    next_active     = active_line;
    next_extra      = extra_sample;
    next_sync_ref   = 1'b0;
    next_running    = (state == pcmf_pkg::pcmf_st_run);
    if (state == pcmf_pkg::pcmf_st_idle) begin
      // idle stream rests at blanking level
      next_word = `PCMF_CODE_BLANK;
    end else if (tim.tick) begin
      next_word     = clipped;
      next_number   = tim.sample_no;
      next_line     = tim.line_no;
      next_field    = tim.field_no;
      next_phase    = tim.phase;
      next_active   = tim.active;
      next_extra    = tim.extra;
      next_sync_ref = tim.sync_ref;
    end
  end

  // register every output
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      video_take     <= 1'b0;
      sample_valid   <= 1'b0;
      sample_word    <= `PCMF_CODE_BLANK;
      sample_number  <= `PCMF_LINE_START;
      line_number    <= `PCMF_FIRST_LINE;
      field_number   <= `PCMF_FIRST_FIELD;
      quad_phase     <= 2'h0;
      active_line    <= 1'b0;
      extra_sample   <= 1'b0;
      sync_reference <= 1'b0;
      running        <= 1'b0;
    end else begin
      video_take     <= next_video_take;
      sample_valid   <= next_valid;
      sample_word    <= next_word;
      sample_number  <= next_number;
      line_number    <= next_line;
      field_number   <= next_field;
      quad_phase     <= next_phase;
      active_line    <= next_active;
      extra_sample   <= next_extra;
      sync_reference <= next_sync_ref;
      running        <= next_running;
    end
  end

endmodule

`default_nettype wire

//--- testbench/pcmf_rx_model.sv
// receiving recorder model that takes and screens the word stream
`timescale 1ns/1ps
`default_nettype none

module pcmf_rx_model (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       sample_valid,
  input  wire logic [9:0] sample_word,
  output var  int         n_words,
  output var  int         n_bad
);
  // ----------------------------------------
  // word capture
  // ----------------------------------------
  // takes all ten bits of each word on its strobe
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      n_words <= 0;
      n_bad <= 0;
    end else if (sample_valid) begin
      n_words <= n_words + 1;
      // excluded codes would be rejected by a recorder
      if (sample_word < 10'h004 || sample_word > 10'h3fb) begin
        n_bad <= n_bad + 1;
      end
    end
  end
endmodule

`default_nettype wire

//--- testbench/pcmf_top_sva.sv
// assertions on the ports of the sample formatter top
`timescale 1ns/1ps
`default_nettype none

module pcmf_top_sva (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        run,
  input wire logic        mode_8bit,
  input wire logic        auto_blank,
  input wire logic [1:0]  level_select,
  input wire logic        video_take,
  input wire logic        sample_valid,
  input wire logic [9:0]  sample_word,
  input wire logic [10:0] sample_number,
  input wire logic [9:0]  line_number,
  input wire logic [1:0]  quad_phase,
  input wire logic        active_line,
  input wire logic        extra_sample,
  input wire logic        sync_reference,
  input wire logic        running
);
  // ----------------------------------------
  // last word seen
  // ----------------------------------------
  logic [10:0] last_n;  // number of previous word
  logic [9:0]  last_ln; // line of previous word
  logic [1:0]  last_ph; // phase of previous word
  logic [10:0] next_n;  // number due after last_n

  // successor in the line numbering
  always_comb begin
    if (last_n == 11'd947) begin
      next_n = 11'd948;
    end else if (last_n == 11'd1134 &&
                 (last_ln == 10'd313 || last_ln == 10'd625)) begin
      next_n = 11'd1135;
    end else if (last_n == 11'd1134 || last_n == 11'd1136) begin
      next_n = 11'd0;
    end else begin
      next_n = last_n + 11'd1;
    end
  end

  // remember each word's position
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      last_n <= 11'd948;
      last_ln <= 10'd1;
      last_ph <= 2'h0;
    end else if (sample_valid) begin
      last_n <= sample_number;
      last_ln <= line_number;
      last_ph <= quad_phase;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  word_range_a: assert property (sample_valid |->
    sample_word >= 10'h004 && sample_word <= 10'h3fb)
    else $error("word outside permitted codes");
  byte_low_a: assert property (sample_valid && $past(mode_8bit) |->
    sample_word[1:0] == 2'h0) else $error("8 bit word low bits set");
  take_valid_a: assert property (video_take |=> sample_valid || !running)
    else $error("no word after take");
  rate_gap_a: assert property (sample_valid && run ##1
    (!sample_valid && run)[*3] |-> 1'b0) else $error("word gap too long");
  phase_step_a: assert property (sample_valid &&
    sample_number != 11'd949 |-> quad_phase == last_ph + 2'h1)
    else $error("phase did not advance");
  number_step_a: assert property (sample_valid &&
    sample_number != 11'd949 |-> sample_number == next_n)
    else $error("sample number out of order");
  line_step_a: assert property (sample_valid &&
    sample_number == 11'd948 && last_n == 11'd947 |-> line_number ==
    ((last_ln == 10'd625) ? 10'd1 : last_ln + 10'd1))
    else $error("line number did not advance");
  active_flag_a: assert property (sample_valid |->
    active_line == (sample_number <= 11'd947))
    else $error("active flag wrong");
  extra_flag_a: assert property (sample_valid && extra_sample |->
    sample_number >= 11'd1135 &&
    (line_number == 10'd313 || line_number == 10'd625))
    else $error("extra sample misplaced");
  sync_ref_a: assert property (sync_reference || sample_valid |->
    sync_reference == (sample_valid && sample_number == 11'd958))
    else $error("sync reference misplaced");
  sync_tip_a: assert property (sample_valid && $past(auto_blank) &&
    $past(level_select) == 2'h0 && sample_number >= 11'd958 &&
    sample_number <= 11'd1040 |-> sample_word == 10'h004)
    else $error("sync tip level wrong");

  // main scenarios reached
  cover property (sample_valid && sample_number == 11'd0);
  cover property (sync_reference && auto_blank);
  cover property (sample_valid && mode_8bit);
endmodule

bind pcmf_top pcmf_top_sva i_pcmf_top_sva (.clk_sys, .resetn, .run,
  .mode_8bit, .auto_blank, .level_select, .video_take, .sample_valid,
  .sample_word, .sample_number, .line_number, .quad_phase, .active_line,
  .extra_sample, .sync_reference, .running);

`default_nettype wire

//--- testbench/pcmf_top_tb.sv
// self-checking bench for the sample formatter top
`timescale 1ns/1ps
`default_nettype none

module pcmf_top_tb;
  logic        clk_sys, resetn, run, mode_8bit, auto_blank;
  logic [1:0]  level_select, quad_phase;
  logic [9:0]  video_in, sample_word, line_number;
  logic [10:0] sample_number;
  logic [3:0]  field_number;
  logic        video_take, sample_valid, active_line, extra_sample;
  logic        sync_reference, running;
  int          mismatches = 0, n_checks = 0, n_words, n_bad;

  pcmf_top i_pcmf_top (.clk_sys, .resetn, .run, .mode_8bit,
    .auto_blank, .level_select, .video_in, .video_take, .sample_valid,
    .sample_word, .sample_number, .line_number, .field_number,
    .quad_phase, .active_line, .extra_sample, .sync_reference, .running);
  pcmf_rx_model i_pcmf_rx_model (.clk_sys, .resetn, .sample_valid,
    .sample_word, .n_words, .n_bad);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // word due for video value v at sample n
  function automatic logic [9:0] exp_word(input logic [9:0] v,
                                          input logic [10:0] n);
    logic [8:0] r;
    if (auto_blank && n >= 11'd948)
      return (n >= 11'd958 && n <= 11'd1040) ? 10'h004 : 10'h100;
    if (level_select == 2'h1) return 10'h100;
    if (level_select == 2'h2) return 10'h34c;
    if (level_select == 2'h3) return 10'h004;
    if (mode_8bit) begin
      r = {1'b0, v[9:2]} + {8'h00, v[1]};
      if (r < 9'h001) r = 9'h001;
      if (r > 9'h0fe) r = 9'h0fe;
      return {r[7:0], 2'h0};
    end
    return (v < 10'h004) ? 10'h004 : ((v > 10'h3fb) ? 10'h3fb : v);
  endfunction

  // stop, check idle, set modes, restart
  task automatic start(input logic m8, input logic ab,
                       input logic [1:0] ls);
    @(negedge clk_sys);
    run = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(sample_word, 10'h100);
    check(running, 1'b0);
    mode_8bit = m8;
    auto_blank = ab;
    level_select = ls;
    video_in = 10'h000;
    run = 1'b1;
  endtask

  // judge n words from a fresh start
  task automatic run_words(input int n);
    logic [10:0] en = 11'd949;
    logic [9:0]  el = 10'd1;
    logic [1:0]  ep = 2'h1;
    int          t;
    for (int i = 0; i < n; i++) begin
      t = 0;
      do begin
        @(negedge clk_sys);
        t++;
      end while (sample_valid !== 1'b1 && t < 20);
      check(sample_valid, 1'b1);
      check(sample_word, exp_word(video_in, en));
      check(sample_number, en);
      check(line_number, el);
      check(field_number, 4'd1);
      check(quad_phase, ep);
      check(active_line, en <= 11'd947);
      check(sync_reference, en == 11'd958);
      check(extra_sample, 1'b0);
      video_in = video_in + 10'h0b7;
      ep = ep + 2'h1;
      if (en == 11'd947) begin
        en = 11'd948;
        el = el + 10'd1;
      end else if (en == 11'd1134) begin
        en = 11'd0;
      end else begin
        en = en + 11'd1;
      end
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    check(sample_word, 10'h100);
    check(sample_number, 11'd948);
    check(line_number, 10'd1);
    check(field_number, 4'd1);
    check(sample_valid, 1'b0);
  endtask

  task automatic t_video;
    start(1'b0, 1'b0, 2'h0);
    run_words(1200);
  endtask

  task automatic t_byte;
    start(1'b1, 1'b0, 2'h0);
    run_words(300);
  endtask

  task automatic t_levels;
    for (int k = 1; k < 4; k++) begin
      start(1'b0, 1'b0, k[1:0]);
      run_words(12);
    end
  endtask

  task automatic t_blank;
    int base;
    start(1'b0, 1'b1, 2'h0);
    base = n_words;
    run_words(200);
    check(n_bad[15:0], 16'h0000);
    @(negedge clk_sys);
    check(16'(n_words - base), 16'd200);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog well beyond the run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end

  initial begin
    resetn = 1'b0;
    run = 1'b0;
    mode_8bit = 1'b0;
    auto_blank = 1'b0;
    level_select = 2'h0;
    video_in = 10'h000;
    repeat (8) @(negedge clk_sys);
    t_reset();
    resetn = 1'b1;
    t_video();
    t_byte();
    t_levels();
    t_blank();
    print_verdict();
  end
endmodule

`default_nettype wire
